// ===== design/hps_pkg.sv
// Package: constants and types for host port select and access log
package hps_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] LAST_WORD_VALUE_LOG_ADDR = 16'hE5FF;
    localparam logic [15:0] LAST_ACCESS_ADDRESS_LOG_ADDR = 16'hE6FE;
    localparam logic [15:0] LAST_HALFWORD_VALUE_LOG_ADDR = 16'hE6FF;
    localparam logic [15:0] SILICON_REVISION_ADDR = 16'hE707;
    localparam logic [15:0] LAST_BYTE_VALUE_LOG_ADDR = 16'hE7FC;
    localparam logic [15:0] LAST_OPERATION_KIND_LOG_ADDR = 16'hE7FD;
    localparam logic [15:0] SECOND_CONFIG_REGISTER_ADDR = 16'hEC01;

    // ------------------------------------------------------------
    // Fields and codes
    // ------------------------------------------------------------
    localparam int unsigned TWO_WIRE_LOCK_BIT = 1;
    localparam logic [7:0] OP_KIND_WRITE = 8'hCA;
    localparam logic [7:0] OP_KIND_READ = 8'h35;
    localparam logic [15:0] WAVEFORM_FIRST_ADDR = 16'hE50C;
    localparam logic [15:0] WAVEFORM_LAST_ADDR = 16'hE51B;
    localparam logic [15:0] ANOMALY_ADDR_STEP = 16'h0001;
    localparam logic [1:0] SELECT_EDGE_COUNT = 2'h3;
    localparam logic [1:0] SELECT_EDGE_STEP = 2'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] LOG_ADDR_RESET = 16'h0000;
    localparam logic [7:0] LOG_OP_RESET = 8'h00;
    localparam logic [31:0] LOG_DATA_RESET = 32'h0000_0000;
    localparam logic [1:0] EDGE_COUNT_RESET = 2'h0;
    localparam logic SELECT_PIN_IDLE = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WIDTH_8,
        WIDTH_16,
        WIDTH_32
    } hps_width_type;

    typedef enum logic [1:0] {
        SEL_PENDING,
        SEL_FOUR_WIRE,
        SEL_TWO_WIRE_LOCKED,
        SEL_FOUR_WIRE_LOCKED
    } hps_sel_type;

    // One finished access reported by the serial framing logic
    typedef struct packed {
        logic        valid;
        logic        ok;
        logic        isWrite;
        logic        viaFourWire;
        logic        burst;
        logic [1:0]  width;
        logic [15:0] addr;
        logic [31:0] data;
        logic [31:0] nextData;
    } hps_access_type;

    // Register lookup for reads served by this block
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } hps_lookup_type;

    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [1:0] count;
    } hps_edge_state_type;

    typedef struct packed {
        hps_sel_type sel;
        logic [15:0] lastAddr;
        logic [7:0]  lastOp;
        logic [7:0]  lastByte;
        logic [15:0] lastHalf;
        logic [31:0] lastWord;
        logic [31:0] rdData;
        logic        rdHit;
        logic        captureEnable;
        logic        twoWireActive;
        logic        fourWireActive;
        logic        portLocked;
    } hps_core_state_type;

endpackage

// ===== design/hps_select_edge_counter.sv
// Select pin synchroniser and falling edge counter
`timescale 1ns/100ps
module hps_select_edge_counter
    import hps_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       clearCount,
    input  wire logic       freeze,
    input  wire logic       selectPin,
    output logic [1:0]      edgeCount
);

    hps_edge_state_type state;
    hps_edge_state_type next_state;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.sync1 = selectPin; // R19
        next_state.sync2 = state.sync1; // R19
        next_state.prev = state.sync2;
        // Only the second stage is looked at, never the first
        if (!freeze && state.prev && !state.sync2 && state.count != SELECT_EDGE_COUNT) begin
            next_state.count = state.count + SELECT_EDGE_STEP; // R19
        end
        if (clearCount) begin
            next_state.sync1 = SELECT_PIN_IDLE;
            next_state.sync2 = SELECT_PIN_IDLE;
            next_state.prev = SELECT_PIN_IDLE;
            next_state.count = EDGE_COUNT_RESET;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        state <= next_state;
    end

    assign edgeCount = state.count;

endmodule

// ===== design/host_port_select_and_access_log.sv
// Host port selection, port lock and last access log
//
// How it works
// R1 - Fast capture port stays disabled after every reset.
// R2 - Only four-wire alone, or two-wire with fast capture port.
// R3 - Select pin held high keeps the two-wire port until hardware reset.
// R4 - Three select pin falling edges switch to four-wire until hardware reset.
// R5 - Host toggles select three times, by plain I/O or three dummy writes.
// R6 - Two-wire lock bit in second config register freezes select and blocks switch.
// R7 - Any second config register write locks an active four-wire port.
// R8 - Lock holds until hardware reset in normal power state or power loss.
// R9 - Power state changes never alter the locked port choice.
// R10 - Successful access stores its 16-bit address in the address log.
// R11 - Operation kind log holds 0xCA after write, 0x35 after read.
// R12 - Data log chosen by width: 8, 16 or 32 bit register.
// R13 - Failed accesses leave every log register unchanged.
// R14 - Reading the log registers does not change them.
// R15 - Anomaly option: four-wire waveform burst reads log address plus one.
// R16 - Host does one other access before trusting logs after waveform bursts.
// R17 - Silicon revision register readable at its own address.
// R18 - Silicon revision register is 8 bits, read only.
// R19 - Select pin synchronised, falling edges counted to three, frozen once locked.
// R20 - All log registers update together in one clock cycle.
`timescale 1ns/100ps
module host_port_select_and_access_log
    import hps_pkg::*;
#(
    parameter logic [7:0] SILICON_REVISION = 8'h01, // Arbitrary value
    parameter logic       WRONG_LOG_ANOMALY = 1'b0
)(
    input  wire logic           core_clk,
    input  wire logic           rst,
    input  wire logic           powerStateNormal,
    input  wire logic           hostSelectPin,
    input  wire logic           fastCaptureRequest,
    input  wire hps_access_type access,
    input  wire hps_lookup_type lookup,
    output logic [31:0]         rdData,
    output logic                rdHit,
    output logic                twoWireActive,
    output logic                fourWireActive,
    output logic                portLocked,
    output logic                fastCaptureEnable
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    hps_core_state_type state;
    hps_core_state_type next_state;
    logic [1:0]         edgeCount;
    logic               selectReset;
    logic               selectFrozen;
    logic               accessDone;
    logic               config2Write;
    logic               logTarget;
    logic               logRead;
    logic               anomalyHit;
    logic [15:0]        logAddr;
    logic [31:0]        logData;

    // ------------------------------------------------------------
    // Select pin edge counter
    // ------------------------------------------------------------
    // Selection state only clears on a reset in the normal power state
    assign selectReset = rst && powerStateNormal; // R8 R9

    // Counter stops once the choice is made or locked
    assign selectFrozen = state.sel != SEL_PENDING; // R6 R19

    hps_select_edge_counter u_edge_counter (
        .core_clk  (core_clk),
        .clearCount(selectReset),
        .freeze    (selectFrozen),
        .selectPin (hostSelectPin),
        .edgeCount (edgeCount)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign accessDone = access.valid && access.ok; // R13

    assign config2Write = accessDone && access.isWrite && access.addr == SECOND_CONFIG_REGISTER_ADDR;

    // Log registers themselves
    always_comb begin
        logTarget = 1'b0;
        unique case (access.addr)
            LAST_WORD_VALUE_LOG_ADDR: logTarget = 1'b1;
            LAST_ACCESS_ADDRESS_LOG_ADDR: logTarget = 1'b1;
            LAST_HALFWORD_VALUE_LOG_ADDR: logTarget = 1'b1;
            LAST_BYTE_VALUE_LOG_ADDR: logTarget = 1'b1;
            LAST_OPERATION_KIND_LOG_ADDR: logTarget = 1'b1;
            default: logTarget = 1'b0;
        endcase
    end

    // Reading a log must not overwrite the record it shows
    assign logRead = accessDone && !access.isWrite && !logTarget; // R14

    // Waveform burst reads over four-wire in the flawed revision
    assign anomalyHit = WRONG_LOG_ANOMALY && access.viaFourWire && access.burst && !access.isWrite
                        && access.addr >= WAVEFORM_FIRST_ADDR && access.addr <= WAVEFORM_LAST_ADDR; // R15

    // Anomaly trades a true record for the prefetched neighbour
    assign logAddr = anomalyHit ? 16'(access.addr + ANOMALY_ADDR_STEP) : access.addr; // R15
    assign logData = anomalyHit ? access.nextData : access.data; // R15

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // Port selection
        unique case (state.sel)
            SEL_PENDING: begin
                if (edgeCount == SELECT_EDGE_COUNT) begin
                    next_state.sel = SEL_FOUR_WIRE; // R4
                end else if (config2Write && access.data[TWO_WIRE_LOCK_BIT]) begin
                    next_state.sel = SEL_TWO_WIRE_LOCKED; // R6
                end
            end
            SEL_FOUR_WIRE: begin
                if (config2Write) begin
                    next_state.sel = SEL_FOUR_WIRE_LOCKED; // R7
                end
            end
            SEL_TWO_WIRE_LOCKED: begin
                next_state.sel = SEL_TWO_WIRE_LOCKED; // R6 R8
            end
            SEL_FOUR_WIRE_LOCKED: begin
                next_state.sel = SEL_FOUR_WIRE_LOCKED; // R7 R8
            end
        endcase

        // Port outputs follow the selection
        next_state.fourWireActive = next_state.sel == SEL_FOUR_WIRE
                                    || next_state.sel == SEL_FOUR_WIRE_LOCKED; // R3 R4
        next_state.twoWireActive = !next_state.fourWireActive; // R3
        next_state.portLocked = next_state.sel == SEL_TWO_WIRE_LOCKED
                                || next_state.sel == SEL_FOUR_WIRE_LOCKED; // R6 R7

        // Fast capture shares pins with four-wire, so only on two-wire
        next_state.captureEnable = fastCaptureRequest && next_state.twoWireActive; // R2

        // Access log, every field in the same cycle
        if ((accessDone && access.isWrite) || logRead) begin
            next_state.lastAddr = logAddr; // R10 R20
            next_state.lastOp = access.isWrite ? OP_KIND_WRITE : OP_KIND_READ; // R11 R20
            unique case (access.width)
                WIDTH_8: next_state.lastByte = logData[7:0]; // R12
                WIDTH_16: next_state.lastHalf = logData[15:0]; // R12
                WIDTH_32: next_state.lastWord = logData; // R12
                default: next_state.lastWord = state.lastWord;
            endcase
        end

        // Register reads served here
        next_state.rdHit = 1'b0;
        next_state.rdData = LOG_DATA_RESET;
        if (lookup.valid) begin
            next_state.rdHit = 1'b1;
            unique case (lookup.addr)
                LAST_WORD_VALUE_LOG_ADDR: next_state.rdData = state.lastWord;
                LAST_ACCESS_ADDRESS_LOG_ADDR: next_state.rdData = {16'h0000, state.lastAddr};
                LAST_HALFWORD_VALUE_LOG_ADDR: next_state.rdData = {16'h0000, state.lastHalf};
                SILICON_REVISION_ADDR: next_state.rdData = {24'h000000, SILICON_REVISION}; // R17 R18
                LAST_BYTE_VALUE_LOG_ADDR: next_state.rdData = {24'h000000, state.lastByte};
                LAST_OPERATION_KIND_LOG_ADDR: next_state.rdData = {24'h000000, state.lastOp};
                default: next_state.rdHit = 1'b0;
            endcase
        end

        // ------------------------------------------------------------
        // Reset
        // ------------------------------------------------------------
        if (rst) begin
            // Capture port off whatever port follows
            next_state.captureEnable = 1'b0; // R1
            next_state.lastAddr = LOG_ADDR_RESET;
            next_state.lastOp = LOG_OP_RESET;
            next_state.lastByte = LOG_DATA_RESET[7:0];
            next_state.lastHalf = LOG_DATA_RESET[15:0];
            next_state.lastWord = LOG_DATA_RESET;
            next_state.rdData = LOG_DATA_RESET;
            next_state.rdHit = 1'b0;
        end
        // Reset outside normal power keeps the locked choice
        if (selectReset) begin
            next_state.sel = SEL_PENDING; // R8
            next_state.twoWireActive = 1'b1; // R3
            next_state.fourWireActive = 1'b0;
            next_state.portLocked = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        state <= next_state;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdData = state.rdData;
    assign rdHit = state.rdHit;
    assign twoWireActive = state.twoWireActive;
    assign fourWireActive = state.fourWireActive;
    assign portLocked = state.portLocked;
    assign fastCaptureEnable = state.captureEnable;

endmodule

// ===== testbench/hps_host_model.sv
// Host model: access reports, register lookups and select pin
`timescale 1ns/100ps
module hps_host_model
    import hps_pkg::*;
(
    input  wire logic      core_clk,
    output hps_access_type access,
    output hps_lookup_type lookup,
    output logic           hostSelectPin
);
    // ----
    // Drivers
    // ----
    initial begin
        access = '0;
        lookup = '0;
        hostSelectPin = SELECT_PIN_IDLE;
    end
    // Released fields flipped so a stale value never passes for a fresh one
    task automatic acc(input logic w, input logic ok, input logic fb, input logic [1:0] wd,
                       input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        #1 access = '{1'b1, ok, w, fb, fb, wd, a, d, ~d};
        @(posedge core_clk);
        #1 access = '{1'b0, 1'b0, ~w, 1'b0, 1'b0, ~wd, ~a, ~d, d};
    endtask
    // Plain I/O toggling, slow enough for the synchroniser
    task automatic toggle();
        @(posedge core_clk);
        #1 hostSelectPin = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 hostSelectPin = 1'b1;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic look(input logic [15:0] a);
        @(posedge core_clk);
        #1 lookup = '{1'b1, a};
        @(posedge core_clk);
        #1 lookup = '{1'b0, ~a};
    endtask
endmodule

// ===== testbench/hps_monitor.sv
// Port assertions for host port select and access log
`timescale 1ns/100ps
module hps_monitor
    import hps_pkg::*;
#(
    parameter logic [7:0] SILICON_REVISION = 8'h01 // Arbitrary value
)(
    input wire logic           core_clk,
    input wire logic           rst,
    input wire logic           powerStateNormal,
    input wire logic           hostSelectPin,
    input wire logic           fastCaptureRequest,
    input wire hps_access_type access,
    input wire hps_lookup_type lookup,
    input wire logic [31:0]    rdData,
    input wire logic           rdHit,
    input wire logic           twoWireActive,
    input wire logic           fourWireActive,
    input wire logic           portLocked,
    input wire logic           fastCaptureEnable
);
    logic [1:0] edgeCnt;
    wire logic  mapped = lookup.addr inside {LAST_WORD_VALUE_LOG_ADDR, LAST_ACCESS_ADDRESS_LOG_ADDR,
        LAST_HALFWORD_VALUE_LOG_ADDR, SILICON_REVISION_ADDR, LAST_BYTE_VALUE_LOG_ADDR, LAST_OPERATION_KIND_LOG_ADDR};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----
    // Raw pin falls, frozen by the lock
    // ----
    always_ff @(posedge core_clk) begin
        if (rst && powerStateNormal) begin
            edgeCnt <= 2'h0;
        end else if ($fell(hostSelectPin) && !portLocked && edgeCnt != 2'h3) begin
            edgeCnt <= edgeCnt + 2'h1;
        end
    end
    sequence thirdFall;
        $fell(hostSelectPin) && edgeCnt == 2'h2 && !portLocked;
    endsequence
    sequence fourWireSoon;
        ##[1:6] fourWireActive;
    endsequence
    a_capture_off_reset: assert property ($fell(rst) |-> !fastCaptureEnable)
        else $error("capture port enabled after reset");
    a_capture_two_wire: assert property (!$past(rst) |->
        fastCaptureEnable == ($past(fastCaptureRequest) && twoWireActive))
        else $error("capture enable wrong");
    a_one_port: assert property (twoWireActive != fourWireActive)
        else $error("port choice not exclusive");
    a_two_wire_hold: assert property (!fourWireActive && edgeCnt != 2'h3 |=> !fourWireActive)
        else $error("four-wire chosen too early");
    a_four_wire_switch: assert property (thirdFall |-> fourWireSoon)
        else $error("four-wire not chosen");
    a_lock_holds: assert property (portLocked |=> portLocked && $stable(fourWireActive))
        else $error("lock lost");
    a_revision_read: assert property (lookup.valid && lookup.addr == SILICON_REVISION_ADDR |=>
        rdHit && rdData == {24'h0, SILICON_REVISION})
        else $error("revision read wrong");
    a_unmapped_miss: assert property (lookup.valid && !mapped |=> !rdHit && rdData == 32'h0)
        else $error("unmapped lookup answered");
    a_idle_quiet: assert property (!lookup.valid |=> !rdHit && rdData == 32'h0)
        else $error("answer without lookup");
endmodule

// ===== testbench/tb_host_port_select_and_access_log.sv
// Testbench for host port select and access log
`timescale 1ns/100ps
module tb_host_port_select_and_access_log
    import hps_pkg::*;
;
    localparam logic [7:0] SILICON_REVISION = 8'h5A; // Arbitrary value
    localparam logic       WRONG_LOG_ANOMALY = 1'b1;
    logic           core_clk = 1'b0;
    logic           rst = 1'b1;
    logic           powerStateNormal = 1'b1;
    logic           fastCaptureRequest = 1'b1;
    logic           hostSelectPin;
    hps_access_type access;
    hps_lookup_type lookup;
    logic [31:0]    rdData;
    logic           rdHit;
    logic           twoWireActive;
    logic           fourWireActive;
    logic           portLocked;
    logic           fastCaptureEnable;
    int             n_fail = 0;
    int             tests_run = 0;
    logic [31:0]    seed = 32'h64C0C6FD;
    logic [31:0]    expQ[$];
    logic [15:0]    logA = 16'h0;
    logic [15:0]    logH = 16'h0;
    logic [7:0]     logOp = 8'h0;
    logic [7:0]     logB = 8'h0;
    logic [31:0]    logW = 32'h0;
    always #5 core_clk = ~core_clk;
    host_port_select_and_access_log #(
        .SILICON_REVISION(SILICON_REVISION),
        .WRONG_LOG_ANOMALY(WRONG_LOG_ANOMALY)
    ) uut (
        .core_clk(core_clk), .rst(rst), .powerStateNormal(powerStateNormal), .hostSelectPin(hostSelectPin),
        .fastCaptureRequest(fastCaptureRequest), .access(access), .lookup(lookup), .rdData(rdData),
        .rdHit(rdHit), .twoWireActive(twoWireActive), .fourWireActive(fourWireActive),
        .portLocked(portLocked), .fastCaptureEnable(fastCaptureEnable));
    hps_host_model host (.core_clk(core_clk), .access(access), .lookup(lookup), .hostSelectPin(hostSelectPin));
    // ----
    // Helpers
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chkPorts(input logic [3:0] e);
        chk({28'h0, twoWireActive, fourWireActive, portLocked, fastCaptureEnable}, {28'h0, e});
    endtask
    task automatic look(input logic [15:0] a, input logic [31:0] e, input logic hit);
        if (hit) expQ.push_back(e);
        host.look(a);
    endtask
    task automatic checkLogs();
        look(LAST_ACCESS_ADDRESS_LOG_ADDR, {16'h0, logA}, 1'b1);
        look(LAST_OPERATION_KIND_LOG_ADDR, {24'h0, logOp}, 1'b1);
        look(LAST_BYTE_VALUE_LOG_ADDR, {24'h0, logB}, 1'b1);
        look(LAST_HALFWORD_VALUE_LOG_ADDR, {16'h0, logH}, 1'b1);
        look(LAST_WORD_VALUE_LOG_ADDR, logW, 1'b1);
    endtask
    task automatic logAcc(input logic w, input logic ok, input logic fb, input logic [1:0] wd,
                          input logic [15:0] a, input logic [31:0] d);
        logic        bad;
        logic [31:0] dd;
        // Flawed revision logs the neighbour on four-wire waveform burst reads
        bad = WRONG_LOG_ANOMALY && fb && !w && a >= WAVEFORM_FIRST_ADDR && a <= WAVEFORM_LAST_ADDR;
        dd = bad ? ~d : d;
        host.acc(w, ok, fb, wd, a, d);
        if (ok && (w || !(a inside {LAST_WORD_VALUE_LOG_ADDR, LAST_ACCESS_ADDRESS_LOG_ADDR,
            LAST_HALFWORD_VALUE_LOG_ADDR, LAST_BYTE_VALUE_LOG_ADDR, LAST_OPERATION_KIND_LOG_ADDR}))) begin
            logA = bad ? 16'(a + 16'h0001) : a;
            logOp = w ? OP_KIND_WRITE : OP_KIND_READ;
            if (wd == 2'h0) logB = dd[7:0];
            if (wd == 2'h1) logH = dd[15:0];
            if (wd == 2'h2) logW = dd;
        end
    endtask
    task automatic doReset(input logic pn);
        @(posedge core_clk);
        #1 rst = 1'b1;
        powerStateNormal = pn;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        powerStateNormal = 1'b1;
        {logA, logOp, logB, logH, logW} = '0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----
    // Answer checker, oldest note first
    // ----
    always @(negedge core_clk) begin
        if (!rst && rdHit === 1'b1 && expQ.size() > 0) chk(rdData, expQ.pop_front());
        else if (!rst && rdHit !== 1'b0) chk({31'h0, rdHit}, 32'h0);
    end
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
    initial begin
        logic [31:0] rnd;
        repeat (19) @(posedge core_clk);
        #1 chkPorts(4'b1000);
        @(posedge core_clk);
        #1 rst = 1'b0;
        @(posedge core_clk);
        #1 chkPorts(4'b1001);
        for (int i = 0; i < 6; i++) begin
            rnd = xs();
            logAcc(i[0], 1'b1, 1'b0, 2'(i / 2), {8'h12, rnd[7:0]}, xs());
            checkLogs();
        end
        logAcc(1'b1, 1'b0, 1'b0, 2'h2, 16'h1300, xs());
        logAcc(1'b0, 1'b1, 1'b0, 2'h1, LAST_ACCESS_ADDRESS_LOG_ADDR, xs());
        checkLogs();
        logAcc(1'b0, 1'b1, 1'b1, 2'h1, WAVEFORM_FIRST_ADDR, xs());
        checkLogs();
        logAcc(1'b0, 1'b1, 1'b0, 2'h0, 16'h1400, xs());
        checkLogs();
        look(SILICON_REVISION_ADDR, {24'h0, SILICON_REVISION}, 1'b1);
        look(16'hEBFF, 32'h0, 1'b0);
        repeat (3) host.toggle();
        repeat (6) @(posedge core_clk);
        #1 chkPorts(4'b0100);
        logAcc(1'b1, 1'b1, 1'b1, 2'h0, SECOND_CONFIG_REGISTER_ADDR, 32'h0);
        repeat (2) @(posedge core_clk);
        #1 chkPorts(4'b0110);
        doReset(1'b0);
        chkPorts(4'b0110);
        doReset(1'b1);
        chkPorts(4'b1001);
        logAcc(1'b1, 1'b1, 1'b0, 2'h0, SECOND_CONFIG_REGISTER_ADDR, 32'h2);
        repeat (3) host.toggle();
        repeat (6) @(posedge core_clk);
        #1 chkPorts(4'b1011);
        fastCaptureRequest = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chkPorts(4'b1010);
        checkLogs();
        repeat (3) @(posedge core_clk);
        chk(expQ.size(), 32'h0);
        print_verdict();
    end
endmodule
bind host_port_select_and_access_log hps_monitor #(.SILICON_REVISION(SILICON_REVISION)) mon (
    .core_clk(core_clk), .rst(rst), .powerStateNormal(powerStateNormal), .hostSelectPin(hostSelectPin),
    .fastCaptureRequest(fastCaptureRequest), .access(access), .lookup(lookup), .rdData(rdData),
    .rdHit(rdHit), .twoWireActive(twoWireActive), .fourWireActive(fourWireActive),
    .portLocked(portLocked), .fastCaptureEnable(fastCaptureEnable));
